// ===== core/panel_video_frame_output.sv
/*
 * Video frame output and trigger logic of a flat-panel image sensor.
 * Trigger pins are sampled on clk_sys; the frame is shaped and driven on
 * the pixel clock pix_clk, which also leaves the device as the grabber's
 * pixel clock. Samples arrive from the digitiser on pix_clk.
 */
`timescale 1ns/1ps

// Functional notes
// - each pixel leaves as one 12-bit sample on the parallel bus
// - bit 0 is the first data line, bit 11 the twelfth
// - array of 1056 by 1056, active area 1032 wide, 1000 high
// - frame is 1000 effective lines then 56 dummy lines
// - line is 1032 effective, 24 dummy pixels, 1877 clocks long
// - only effective pixels carry image data, others read zero
// - external mode: video starts a fixed delay after trigger rise
// - internal mode runs at four frames per second
// - external rate from internal rate down to one frame per second
module panel_video_frame_output
    import frame_output_pkg::*;
#(
    parameter int unsigned FRAME_PERIOD_CYCLES =
        `PVF_SYS_CLK_HZ / `PVF_INT_FPS,
    parameter int unsigned TVD_CYCLES = `PVF_TVD_CYCLES
) (
    // system clock and reset
    input  wire logic                     clk_sys,
    input  wire logic                     sys_rst,
    // trigger pins, idle high
    input  wire logic                     grabber_trigger_in,
    input  wire logic                     connector_trigger_in,
    input  wire logic                     trigger_source_select,
    // pixel clock, also forwarded to the grabber
    input  wire logic                     pix_clk,
    // samples from the digitiser, on pix_clk
    input  wire logic [`PVF_SAMPLE_W-1:0] sample_data,
    input  wire logic                     sample_valid,
    output      logic                     sample_ready,
    // video toward the grabber
    output      video_out_t               video_out
);

    localparam logic [`PVF_TIMER_W-1:0] TIMER_LAST =
        `PVF_TIMER_W'(FRAME_PERIOD_CYCLES - 1);
    localparam logic [`PVF_DELAY_W-1:0] DELAY_LAST =
        `PVF_DELAY_W'(TVD_CYCLES - 1);

    localparam sys_state_t SYS_RESET = '{
        pin_meta:  `PVF_PIN_IDLE,
        pin_sync:  `PVF_PIN_IDLE,
        ext_prev:  1'b1,
        src:       SRC_EXTERNAL,
        timer:     '0,
        delay_run: 1'b0,
        delay_cnt: '0,
        start_tgl: 1'b0,
        busy_meta: 1'b0,
        busy_sync: 1'b0
    };

    // system clock domain: trigger capture, frame timer, delay

    sys_state_t s_reg;
    sys_state_t s_next;
    pix_state_t p_reg;
    pix_state_t p_next;

    logic ext_level;
    logic ext_rise;
    logic frame_ready;

    always_comb begin
        s_next = s_reg;
        // pins are outside any clock: two flops before use
        s_next.pin_meta = {trigger_source_select, connector_trigger_in,
                           grabber_trigger_in};
        s_next.pin_sync = s_reg.pin_meta;
        // busy level from the pixel domain
        s_next.busy_meta = p_reg.active;
        s_next.busy_sync = s_reg.busy_meta;

        // both trigger pins idle high, so the unused one never masks
        // the other one's pulse
        ext_level = s_reg.pin_sync[0] && s_reg.pin_sync[1];
        ext_rise  = ext_level && !s_reg.ext_prev;
        s_next.ext_prev = ext_level;

        // select high or open means external triggering
        s_next.src = frame_src_t'(s_reg.pin_sync[2]);

        // timer saturates once a whole internal period has passed
        if (s_reg.timer != TIMER_LAST) begin
            s_next.timer = s_reg.timer + `PVF_TIMER_W'(1);
        end

        // a new frame needs the old one finished and one period gone,
        // so no source can run faster than the internal rate
        frame_ready = (s_reg.timer == TIMER_LAST) && !s_reg.delay_run
                      && !s_reg.busy_sync;

        unique case (s_reg.src)
            SRC_INTERNAL: begin
                if (frame_ready) begin
                    s_next.timer     = '0;
                    s_next.start_tgl = ~s_reg.start_tgl;
                end
            end
            SRC_EXTERNAL: begin
                // triggers that come too early are dropped, not queued
                if (ext_rise && frame_ready) begin
                    s_next.timer     = '0;
                    s_next.delay_run = 1'b1;
                    s_next.delay_cnt = DELAY_LAST;
                end
            end
        endcase

        // the delay finishes even if the select pin moves meanwhile
        if (s_reg.delay_run) begin
            if (s_reg.delay_cnt == '0) begin
                s_next.delay_run = 1'b0;
                s_next.start_tgl = ~s_reg.start_tgl;
            end else begin
                s_next.delay_cnt = s_reg.delay_cnt - `PVF_DELAY_W'(1);
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            s_reg <= SYS_RESET;
        end else begin
            s_reg <= s_next;
        end
    end

    // pixel clock domain: reset, buffer, frame shaping

    logic [1:0] rst_pix_pipe;
    logic       rst_pix;

    // reset reaches pix_clk through two flops; needs pix_clk running
    always_ff @(posedge pix_clk) begin
        rst_pix_pipe <= {rst_pix_pipe[0], sys_rst};
    end
    assign rst_pix = rst_pix_pipe[1];

    logic                     buf_valid;
    logic                     buf_ready;
    logic [`PVF_SAMPLE_W-1:0] buf_data;

    // the buffer holds samples across blanking; when it is full the
    // digitiser sees sample_ready low and waits
    pixel_skid_fifo2 #(
        .WIDTH     (`PVF_SAMPLE_W)
    ) u_sample_buf (
        .clk       (pix_clk),
        .rst       (rst_pix),
        .in_valid  (sample_valid),
        .in_ready  (sample_ready),
        .in_data   (sample_data),
        .out_valid (buf_valid),
        .out_ready (buf_ready),
        .out_data  (buf_data)
    );

    logic start_pulse;
    logic last_pix;
    logic last_line;
    logic eff_pix;

    always_comb begin
        p_next = p_reg;
        // start toggle crosses by two flops, edge taken on the second
        p_next.start_meta = s_reg.start_tgl;
        p_next.start_sync = p_reg.start_meta;
        p_next.start_seen = p_reg.start_sync;
        start_pulse = p_reg.start_sync ^ p_reg.start_seen;

        last_pix  = (p_reg.pix_cnt == `PVF_LINE_PCLK - 11'h001);
        last_line = (p_reg.line_cnt == `PVF_FRAME_LINES - 11'h001);

        // effective window of the effective lines
        eff_pix = p_reg.active
                  && (p_reg.line_cnt < `PVF_EFF_LINES)
                  && (p_reg.pix_cnt < `PVF_EFF_PIX);
        buf_ready = eff_pix;

        if (p_reg.active) begin
            if (last_pix) begin
                p_next.pix_cnt = '0;
                if (last_line) begin
                    p_next.active   = 1'b0;
                    p_next.line_cnt = '0;
                end else begin
                    p_next.line_cnt = p_reg.line_cnt + 11'h001;
                end
            end else begin
                p_next.pix_cnt = p_reg.pix_cnt + 11'h001;
            end
        end else if (start_pulse) begin
            p_next.active   = 1'b1;
            p_next.pix_cnt  = '0;
            p_next.line_cnt = '0;
        end

        // outputs are registered and follow the counters by one clock
        p_next.video.vsync = p_reg.active;
        p_next.video.hsync = p_reg.active
                             && (p_reg.pix_cnt < `PVF_HSYNC_PCLK);
        // dummy pixels and an empty buffer both put out zero
        if (eff_pix && buf_valid) begin
            p_next.video.data = buf_data;
        end else begin
            p_next.video.data = '0;
        end
    end

    // all video outputs change on the rising pixel clock only
    always_ff @(posedge pix_clk) begin
        if (rst_pix) begin
            p_reg <= '0;
        end else begin
            p_reg <= p_next;
        end
    end

    // data[0] is the first data line, data[11] the twelfth
    assign video_out = p_reg.video;

endmodule // panel_video_frame_output

// ===== include/frame_timing_map.svh
/*
 * Timing counts, widths and reset values of the panel video frame output.
 * Assumes it is included by its bare name from the package and the
 * bench; definitions only.
 */
`ifndef FRAME_TIMING_MAP_SVH
`define FRAME_TIMING_MAP_SVH

// sample width on the parallel data bus
`define PVF_SAMPLE_W         12

// frame geometry, lines counted in hsync pulses, pixels in pixel clocks
`define PVF_EFF_LINES        11'h3E8
`define PVF_DUMMY_LINES      11'h038
`define PVF_FRAME_LINES      (`PVF_EFF_LINES + `PVF_DUMMY_LINES)
`define PVF_EFF_PIX          11'h408
`define PVF_DUMMY_PIX        11'h018
`define PVF_DATA_PIX         (`PVF_EFF_PIX + `PVF_DUMMY_PIX)
`define PVF_HSYNC_PCLK       11'h74E
`define PVF_LINE_PCLK        11'h755
`define PVF_CNT_W            11

// system clock and internal frame rate
`define PVF_SYS_CLK_HZ       50000000
`define PVF_INT_FPS          4
`define PVF_TIMER_W          24

// trigger to video delay in system clocks, no figure given
`define PVF_TVD_CYCLES       100
`define PVF_DELAY_W          16

// trigger pins idle high when unconnected
`define PVF_PIN_IDLE         3'h7

`endif

// ===== include/frame_output_pkg.sv
/*
 * Types of the panel video frame output.
 * Assumes frame_timing_map.svh is reachable on the include path.
 */
`include "frame_timing_map.svh"

package frame_output_pkg;

    typedef enum logic {
        SRC_INTERNAL = 1'b0,
        SRC_EXTERNAL = 1'b1
    } frame_src_t;

    typedef struct packed {
        logic                     vsync;
        logic                     hsync;
        logic [`PVF_SAMPLE_W-1:0] data;
    } video_out_t;

    typedef struct packed {
        logic [2:0]               pin_meta;
        logic [2:0]               pin_sync;
        logic                     ext_prev;
        frame_src_t               src;
        logic [`PVF_TIMER_W-1:0]  timer;
        logic                     delay_run;
        logic [`PVF_DELAY_W-1:0]  delay_cnt;
        logic                     start_tgl;
        logic                     busy_meta;
        logic                     busy_sync;
    } sys_state_t;

    typedef struct packed {
        logic                     start_meta;
        logic                     start_sync;
        logic                     start_seen;
        logic                     active;
        logic [`PVF_CNT_W-1:0]    pix_cnt;
        logic [`PVF_CNT_W-1:0]    line_cnt;
        video_out_t               video;
    } pix_state_t;

endpackage

// ===== core/pixel_skid_fifo2.sv
/*
 * Two-entry buffer with valid and ready on both sides.
 * Assumes one clock for both sides and a synchronous active-high reset.
 */
`timescale 1ns/1ps

module pixel_skid_fifo2 #(
    parameter int WIDTH = 12
) (
    // clock and reset
    input  wire logic             clk,
    input  wire logic             rst,
    // filling side
    input  wire logic             in_valid,
    output      logic             in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // draining side
    output      logic             out_valid,
    input  wire logic             out_ready,
    output      logic [WIDTH-1:0] out_data
);

    typedef struct packed {
        logic [1:0][WIDTH-1:0] mem;
        logic                  wr_ptr;
        logic                  rd_ptr;
        logic [1:0]            count;
    } fifo_state_t;

    fifo_state_t f_reg;
    fifo_state_t f_next;
    logic        push;
    logic        pop;

    assign in_ready  = (f_reg.count != 2'h2);
    assign out_valid = (f_reg.count != 2'h0);
    assign out_data  = f_reg.mem[f_reg.rd_ptr];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always_comb begin
        f_next = f_reg;
        if (push) begin
            f_next.mem[f_reg.wr_ptr] = in_data;
            f_next.wr_ptr            = ~f_reg.wr_ptr;
        end
        if (pop) begin
            f_next.rd_ptr = ~f_reg.rd_ptr;
        end
        // push and pop together leave the fill level unchanged
        if (push && !pop) begin
            f_next.count = f_reg.count + 2'h1;
        end else if (pop && !push) begin
            f_next.count = f_reg.count - 2'h1;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            f_reg <= '0;
        end else begin
            f_reg <= f_next;
        end
    end

endmodule // pixel_skid_fifo2

// ===== sim/video_out_chk.sv
/* checker of the video output: sync shape, blanking, buffer, trigger.
   assumes only the top ports; bound to the top below */
`timescale 1ns/1ps
module video_out_chk
    import frame_output_pkg::*;
#(
    parameter int unsigned FRAME_PERIOD_CYCLES = 3000,
    parameter int unsigned TVD_CYCLES = 4
) (
    // clocks and reset
    input wire logic       clk_sys,
    input wire logic       sys_rst,
    input wire logic       pix_clk,
    // pins and video
    input wire logic       grabber_trigger_in,
    input wire logic       connector_trigger_in,
    input wire logic       trigger_source_select,
    input wire logic       sample_valid,
    input wire logic       sample_ready,
    input wire video_out_t video_out
);
    logic [10:0] hs_cnt;
    logic [15:0] trg_age;
    logic [23:0] up_cnt;
    logic        trg_prev;
    wire         trg_now = grabber_trigger_in & connector_trigger_in;

    always_ff @(posedge pix_clk) begin
        if (sys_rst)
            hs_cnt <= 11'h000;
        else
            hs_cnt <= video_out.hsync ? hs_cnt + 11'h001 : 11'h000;
    end

    // trigger age counts from the raw pin edge, before synchronising
    always_ff @(posedge clk_sys) begin
        trg_prev <= trg_now;
        if (sys_rst)
            up_cnt <= 24'h000000;
        else if (up_cnt != 24'hFFFFFF)
            up_cnt <= up_cnt + 24'h000001;
        if (sys_rst || (trg_now && !trg_prev))
            trg_age <= 16'h0000;
        else if (trg_age != 16'hFFFF)
            trg_age <= trg_age + 16'h0001;
    end

    sequence line_gap;
        !video_out.hsync [*7] ##1 (video_out.hsync || !video_out.vsync);
    endsequence

    a_hsync_len: assert property (@(posedge pix_clk)
        disable iff (sys_rst) $fell(video_out.hsync) |-> hs_cnt == 11'h74E)
        else $error("hsync width wrong");
    a_line_gap: assert property (@(posedge pix_clk)
        disable iff (sys_rst) $fell(video_out.hsync) |-> line_gap)
        else $error("line gap wrong");
    a_sync_frame: assert property (@(posedge pix_clk)
        disable iff (sys_rst) !video_out.vsync |->
        !video_out.hsync && video_out.data == 12'h000)
        else $error("activity outside frame");
    a_frame_begin: assert property (@(posedge pix_clk)
        disable iff (sys_rst) $rose(video_out.vsync) |->
        video_out.hsync && hs_cnt == 11'h000)
        else $error("frame not on line start");
    a_blank_data: assert property (@(posedge pix_clk)
        disable iff (sys_rst) !video_out.hsync |-> video_out.data == 12'h000)
        else $error("data in line gap");
    a_dummy_pix: assert property (@(posedge pix_clk)
        disable iff (sys_rst) video_out.hsync && hs_cnt >= 11'h408 |->
        video_out.data == 12'h000)
        else $error("data in dummy pixel");
    a_buf_full: assert property (@(posedge pix_clk)
        disable iff (sys_rst) (!video_out.vsync && sample_valid) [*3] |->
        !sample_ready)
        else $error("buffer takes a third word");
    a_no_early: assert property (@(posedge clk_sys)
        disable iff (sys_rst) up_cnt < FRAME_PERIOD_CYCLES - 1 |->
        !video_out.vsync)
        else $error("frame before timer ran out");
    a_trig_delay: assert property (@(posedge clk_sys)
        disable iff (sys_rst) trigger_source_select &&
        $rose(video_out.vsync) |-> trg_age >= TVD_CYCLES &&
        trg_age <= TVD_CYCLES + 40)
        else $error("trigger to video delay wrong");
endmodule // video_out_chk

bind panel_video_frame_output video_out_chk #(
    .FRAME_PERIOD_CYCLES(FRAME_PERIOD_CYCLES),
    .TVD_CYCLES(TVD_CYCLES)
) chk (.clk_sys, .sys_rst, .pix_clk, .grabber_trigger_in,
    .connector_trigger_in, .trigger_source_select, .sample_valid,
    .sample_ready, .video_out);

// ===== sim/grabber_model.sv
/* frame grabber model: captures pixels with row and column.
   assumes the video moves on the rising pixel clock */
`timescale 1ns/1ps
module grabber_model
    import frame_output_pkg::*;
(
    // pixel clock and video
    input  wire logic        pix_clk,
    input  wire video_out_t  video_in,
    // captured pixel
    output      logic        px_take,
    output      logic [15:0] px_data,
    output      logic [10:0] px_col,
    output      logic [10:0] px_row
);
    logic hs_prev = 1'b0;
    logic vs_prev = 1'b0;
    // mid-cycle sampling keeps clear of the launching edge
    always @(negedge pix_clk) begin
        px_take <= video_in.vsync && video_in.hsync;
        px_data <= {4'h0, video_in.data};
        if (video_in.hsync && !hs_prev) begin
            px_col <= 11'h000;
            px_row <= vs_prev ? px_row + 11'h001 : 11'h000;
        end else if (video_in.hsync) begin
            px_col <= px_col + 11'h001;
        end
        hs_prev <= video_in.hsync;
        vs_prev <= video_in.vsync;
    end
endmodule // grabber_model

// ===== sim/tb_top.sv
/* bench of the video output: triggers, pixel stream, second reset.
   assumes the design, the grabber model and the bound checker */
`timescale 1ns/1ps
`include "frame_timing_map.svh"
module tb_top;
    import frame_output_pkg::*;
    localparam int unsigned FP = 3000;
    logic        clk_sys = 1'b0;
    logic        pix_clk = 1'b0;
    logic        sys_rst = 1'b1;
    logic        grabber_trigger_in = 1'b1;
    logic        connector_trigger_in = 1'b1;
    logic        trigger_source_select = 1'b1;
    logic [11:0] sample_data = 12'h000;
    logic        sample_valid = 1'b0;
    logic        sample_ready;
    video_out_t  video_out;
    logic        px_take;
    logic [15:0] px_data;
    logic [10:0] px_col;
    logic [10:0] px_row;
    logic        go = 1'b0;
    logic        watch = 1'b0;
    logic        took = 1'b0;
    int          seed = 32'hC40B2E55;
    int          fails = 0;
    int          check_count = 0;
    int          n;
    logic [11:0] q[$];

    always #10 clk_sys = ~clk_sys;
    always #15 pix_clk = ~pix_clk;

    panel_video_frame_output #(.FRAME_PERIOD_CYCLES(FP), .TVD_CYCLES(4))
    uut (.clk_sys(clk_sys), .sys_rst(sys_rst),
        .grabber_trigger_in(grabber_trigger_in),
        .connector_trigger_in(connector_trigger_in),
        .trigger_source_select(trigger_source_select),
        .pix_clk(pix_clk), .sample_data(sample_data),
        .sample_valid(sample_valid), .sample_ready(sample_ready),
        .video_out(video_out));

    grabber_model grab (.pix_clk(pix_clk), .video_in(video_out),
        .px_take(px_take), .px_data(px_data), .px_col(px_col),
        .px_row(px_row));

    function automatic logic [15:0] exp_pix(input logic [10:0] c, r);
        if (c >= `PVF_EFF_PIX || r >= `PVF_EFF_LINES)
            return 16'h0000;
        if (q.size() == 0)
            return 16'hFFFF;
        return {4'h0, q.pop_front()};
    endfunction

    task automatic cmp_flag(input logic got, exp, input string what);
        check_count++;
        if (got !== exp) begin
            fails++;
            $display("mismatch at %0t: %s", $time, what);
        end
    endtask

    task automatic cmp_pix(input logic [15:0] got, exp);
        check_count++;
        if (got !== exp) begin
            fails++;
            $display("mismatch at %0t: pixel %h not %h", $time, got, exp);
        end
    endtask

    task automatic give_verdict;
        $display("checks %0d, fails %0d", check_count, fails);
        if (fails == 0 && check_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task automatic pulse(input logic use_conn);
        if (use_conn)
            connector_trigger_in = 1'b0;
        else
            grabber_trigger_in = 1'b0;
        repeat (4) @(negedge clk_sys);
        connector_trigger_in = 1'b1;
        grabber_trigger_in = 1'b1;
    endtask

    task automatic wait_vsync(input int lim);
        n = 0;
        while (video_out.vsync !== 1'b1 && n < lim) begin
            @(negedge clk_sys);
            n++;
        end
        // only a frame that never came counts, not one on the last step
        if (video_out.vsync !== 1'b1) begin
            fails++;
            give_verdict();
        end
    endtask

    task automatic wait_row(input logic [10:0] r);
        for (int i = 0; px_row !== r; i++) begin
            if (i > 12000) begin
                fails++;
                give_verdict();
            end
            @(negedge clk_sys);
        end
    endtask

    task automatic hold_reset;
        sys_rst = 1'b1;
        repeat (12) @(negedge clk_sys);
        sys_rst = 1'b0;
        repeat (10) @(negedge clk_sys);
        go = 1'b1;
        watch = 1'b1;
    endtask

    always @(negedge pix_clk) begin
        sample_valid <= go;
        if (took || !sample_valid)
            sample_data <= 12'($random(seed));
    end

    always @(posedge pix_clk) begin
        took <= sample_valid && sample_ready;
        if (sys_rst)
            q.delete();
        else if (sample_valid && sample_ready)
            q.push_back(sample_data);
        if (watch && px_take)
            cmp_pix(px_data, exp_pix(px_col, px_row));
    end

    initial begin
        hold_reset();
        repeat (20) @(negedge clk_sys);
        cmp_flag(sample_ready, 1'b0, "buffer took a third word");
        pulse(1'b0);
        repeat (200) @(negedge clk_sys);
        cmp_flag(video_out.vsync, 1'b0, "early trigger taken");
        repeat (FP + ($random(seed) & 63)) @(negedge clk_sys);
        pulse(1'b1);
        wait_vsync(60);
        cmp_flag(video_out.hsync, 1'b1, "frame without line");
        wait_row(11'h002);
        go = 1'b0;
        watch = 1'b0;
        repeat (4) @(negedge clk_sys);
        trigger_source_select = 1'b0;
        hold_reset();
        cmp_flag(video_out.vsync, 1'b0, "frame kept over reset");
        wait_vsync(FP + 100);
        cmp_flag(n >= FP - 30, 1'b1, "internal frame early");
        wait_row(11'h001);
        give_verdict();
    end
endmodule // tb_top
